// ===== rtl/iopm_io_port.sv
// two gpio ports plus micro control register, reached by data-space and i/o accesses
// Functional notes
// [RQ1] Software arms brown-out sleep off by writing it with its unlock bit, then within four cycles writing it alone.
// [RQ2] The brown-out sleep-off bit becomes active three cycles after a valid timed write and clears itself three cycles later.
// [RQ3] The detector is off for a sleep only if sleep executes while the sleep-off bit is active.
// [RQ4] With pull-up kill set every port pull-up is off regardless of direction and output bits.
// [RQ5] Vector select zero places vectors at flash start, one at the boot section base set by the boot size fuses.
// [RQ6] Software changes vector select by writing the change unlock bit, then within four cycles the new value with unlock zero.
// [RQ7] Interrupts are masked from the unlock write until after the instruction after the select write, or four cycles.
// [RQ8] The automatic masking leaves the global interrupt enable flag untouched.
// [RQ9] Hardware clears the vector change unlock bit four cycles after writing it or when vector select is written.
// [RQ10] Boot lock bits block interrupts while executing from the section that does not hold the vectors.
// [RQ11] Each register decodes at its data-space offset and at that offset minus 0x20 for i/o accesses.
// [RQ12] Each direction bit sets its pin direction and all reset to zero.
// [RQ13] Writing an input-pins register toggles output bits written with one and stores nothing.
// [RQ14] Port c implements only bits 0 to 6.
// [RQ15] Output registers reset to zero and input-pins registers reflect pins.
// [RQ16] Input-pins reads return synchronised pin levels with unimplemented bits reading zero.
`timescale 1ns/1ps
`include "iopm_consts.svh"
module iopm_io_port
  import iopm_pkg::*;
#(
  parameter int unsigned PB_WIDTH = 8,
  parameter int unsigned PC_WIDTH = 7
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic [7:0]          addr_i,
  input  wire logic                io_space_i,
  input  wire logic                wr_en_i,
  input  wire logic                rd_en_i,
  input  wire logic [7:0]          wdata_i,
  output logic      [7:0]          rdata_o,
  input  wire logic                sleep_exec_i,
  input  wire logic                pc_in_boot_i,
  input  wire logic                app_section_lock_i,
  input  wire logic                boot_section_lock_i,
  input  wire logic                global_irq_en_i,
  input  wire logic [PB_WIDTH-1:0] pb_pin_i,
  input  wire logic [PC_WIDTH-1:0] pc_pin_i,
  output logic      [PB_WIDTH-1:0] pb_pin_o,
  output logic      [PB_WIDTH-1:0] pb_pin_oe_o,
  output logic      [PB_WIDTH-1:0] pb_pullup_o,
  output logic      [PC_WIDTH-1:0] pc_pin_o,
  output logic      [PC_WIDTH-1:0] pc_pin_oe_o,
  output logic      [PC_WIDTH-1:0] pc_pullup_o,
  output logic                     vector_table_select_o,
  output logic                     irq_allowed_o,
  output logic                     brownout_sleep_off_o,
  output logic                     brownout_detector_off_o
);

  // each port must fit the single byte lane of the register bus
  if (PB_WIDTH < 1 || PB_WIDTH > 8 || PC_WIDTH < 1 || PC_WIDTH > 8) begin : g_width_chk
    $error("port widths must lie between 1 and 8");
  end

  // full data-space address of either access kind
  function automatic logic [7:0] ds_addr(input logic [7:0] a, input logic io);
    ds_addr = io ? ((a <= `IOPM_IO_SPACE_MAX) ? a + `IOPM_IO_OFFSET : 8'hff) : a;
  endfunction

  function automatic logic [7:0] pad8(input logic [7:0] v, input int unsigned w);
    logic [7:0] m;
    m = 8'hff >> (8 - w);
    pad8 = v & m;
  endfunction

  // one step of a window counter that parks at zero
  function automatic logic [2:0] count_down(input logic [2:0] c);
    count_down = (c == 3'h0) ? 3'h0 : c - 3'h1;
  endfunction

  logic [PB_WIDTH-1:0] pb_out_ff;
  logic [PB_WIDTH-1:0] pb_dir_ff;
  logic [PB_WIDTH-1:0] pb_s1_ff;
  logic [PB_WIDTH-1:0] pb_s2_ff;
  logic [PC_WIDTH-1:0] pc_out_ff;
  logic [PC_WIDTH-1:0] pc_dir_ff;
  logic [PC_WIDTH-1:0] pc_s1_ff;
  logic [PC_WIDTH-1:0] pc_s2_ff;
  logic                pullup_kill_ff;
  logic                vec_sel_ff;
  logic                vec_unlock_ff;
  logic [2:0]          vec_cnt_ff;
  logic                irq_hold_ff;
  logic                bod_unlock_ff;
  logic [2:0]          bod_unlock_cnt_ff;
  iopm_bod_st_t        bod_st_ff;
  logic [2:0]          bod_cnt_ff;
  logic [7:0]          rdata_ff;

  wire [7:0] eff_addr = ds_addr(addr_i, io_space_i); // RQ11
  wire sel_pb_in  = eff_addr == `IOPM_OFF_PB_IN;
  wire sel_pb_dir = eff_addr == `IOPM_OFF_PB_DIR;
  wire sel_pb_out = eff_addr == `IOPM_OFF_PB_OUT;
  wire sel_pc_in  = eff_addr == `IOPM_OFF_PC_IN;
  wire sel_pc_dir = eff_addr == `IOPM_OFF_PC_DIR;
  wire sel_pc_out = eff_addr == `IOPM_OFF_PC_OUT;
  wire sel_mctl   = eff_addr == `IOPM_OFF_MCTL;
  wire wr_mctl    = wr_en_i && sel_mctl;

  wire w_bod_off  = wdata_i[`IOPM_BIT_BOD_OFF];
  wire w_bod_unl  = wdata_i[`IOPM_BIT_BOD_UNLOCK];
  wire w_vec_sel  = wdata_i[`IOPM_BIT_VEC_SEL];
  wire w_vec_unl  = wdata_i[`IOPM_BIT_VEC_UNLOCK];

  // vector change sequence
  wire vec_open   = vec_unlock_ff && vec_cnt_ff != 3'h0;
  wire vec_arm    = wr_mctl && w_vec_unl;
  wire vec_commit = wr_mctl && !w_vec_unl && vec_open; // RQ6
  wire [2:0] nxt_vec_cnt = vec_arm    ? `IOPM_UNLOCK_CYC :
                           vec_commit ? 3'h0 : count_down(vec_cnt_ff); // RQ9

  // brown-out timed sequence
  wire bod_open   = bod_unlock_ff && bod_unlock_cnt_ff != 3'h0;
  wire bod_arm    = wr_mctl && w_bod_off && w_bod_unl;
  wire bod_commit = wr_mctl && w_bod_off && !w_bod_unl && bod_open; // RQ1
  // a late second write finds the window shut and is dropped
  wire [2:0] nxt_bod_unlock_cnt = bod_arm ? `IOPM_UNLOCK_CYC : count_down(bod_unlock_cnt_ff);

  wire [PB_WIDTH-1:0] w_pb = wdata_i[PB_WIDTH-1:0];
  wire [PC_WIDTH-1:0] w_pc = wdata_i[PC_WIDTH-1:0]; // RQ14
  wire [PB_WIDTH-1:0] nxt_pb_out = (wr_en_i && sel_pb_out) ? w_pb :
                                   (wr_en_i && sel_pb_in) ? pb_out_ff ^ w_pb : pb_out_ff; // RQ13
  wire [PC_WIDTH-1:0] nxt_pc_out = (wr_en_i && sel_pc_out) ? w_pc :
                                   (wr_en_i && sel_pc_in) ? pc_out_ff ^ w_pc : pc_out_ff; // RQ13

  wire [7:0] mctl_view = {1'b0, brownout_sleep_off_o, bod_unlock_ff, pullup_kill_ff,
                          2'b00, vec_sel_ff, vec_unlock_ff};
  wire [7:0] nxt_rdata = !rd_en_i   ? `IOPM_RST_BYTE :
                         sel_pb_in  ? pad8(8'(pb_s2_ff), PB_WIDTH) : // RQ16
                         sel_pb_dir ? pad8(8'(pb_dir_ff), PB_WIDTH) :
                         sel_pb_out ? pad8(8'(pb_out_ff), PB_WIDTH) :
                         sel_pc_in  ? pad8(8'(pc_s2_ff), PC_WIDTH) : // RQ16
                         sel_pc_dir ? pad8(8'(pc_dir_ff), PC_WIDTH) :
                         sel_pc_out ? pad8(8'(pc_out_ff), PC_WIDTH) :
                         sel_mctl   ? mctl_view : `IOPM_RST_BYTE;

  // brown-out state: delay three cycles, active three cycles, then self clear
  iopm_bod_st_t nxt_bod_st;
  logic [2:0]   nxt_bod_cnt;
  always_comb begin
    nxt_bod_st  = bod_st_ff;
    nxt_bod_cnt = bod_cnt_ff;
    case (bod_st_ff)
      IOPM_BOD_IDLE: begin
        if (bod_commit) begin
          nxt_bod_st  = IOPM_BOD_DELAY;
          nxt_bod_cnt = `IOPM_BOD_DELAY_CYC - 3'h1;
        end
      end
      IOPM_BOD_DELAY: begin
        if (bod_cnt_ff == 3'h0) begin
          nxt_bod_st  = IOPM_BOD_ACTIVE; // RQ2
          nxt_bod_cnt = `IOPM_BOD_HOLD_CYC - 3'h1;
        end else begin
          nxt_bod_cnt = bod_cnt_ff - 3'h1;
        end
      end
      IOPM_BOD_ACTIVE: begin
        if (bod_cnt_ff == 3'h0) begin
          nxt_bod_st = IOPM_BOD_IDLE; // RQ2
        end else begin
          nxt_bod_cnt = bod_cnt_ff - 3'h1;
        end
      end
      default: begin
        nxt_bod_st  = IOPM_BOD_IDLE;
        nxt_bod_cnt = 3'h0;
      end
    endcase
  end

  // first stage may go metastable; only the second stage feeds logic
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pb_s1_ff <= '0;
      pb_s2_ff <= '0;
    end else begin
      pb_s1_ff <= pb_pin_i;
      pb_s2_ff <= pb_s1_ff;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_s1_ff <= '0;
      pc_s2_ff <= '0;
    end else begin
      pc_s1_ff <= pc_pin_i;
      pc_s2_ff <= pc_s1_ff;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pb_out_ff <= '0; // RQ15
    end else begin
      pb_out_ff <= nxt_pb_out;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_out_ff <= '0; // RQ15
    end else begin
      pc_out_ff <= nxt_pc_out;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pb_dir_ff <= '0; // RQ12
    end else if (wr_en_i && sel_pb_dir) begin
      pb_dir_ff <= w_pb; // RQ12
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_dir_ff <= '0; // RQ12
    end else if (wr_en_i && sel_pc_dir) begin
      pc_dir_ff <= w_pc; // RQ12
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= `IOPM_RST_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pullup_kill_ff <= 1'b0;
    end else if (wr_mctl) begin
      pullup_kill_ff <= wdata_i[`IOPM_BIT_PULLUP_KILL]; // RQ4
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_sel_ff <= 1'b0;
    end else if (vec_commit) begin
      vec_sel_ff <= w_vec_sel; // RQ6
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_unlock_ff <= 1'b0;
      vec_cnt_ff    <= 3'h0;
    end else begin
      vec_unlock_ff <= (nxt_vec_cnt != 3'h0); // RQ9
      vec_cnt_ff    <= nxt_vec_cnt;
    end
  end

  // the mask outlives the select write by one instruction
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_hold_ff <= 1'b0;
    end else begin
      irq_hold_ff <= vec_commit; // RQ7
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bod_unlock_ff     <= 1'b0;
      bod_unlock_cnt_ff <= 3'h0;
    end else begin
      bod_unlock_ff     <= (nxt_bod_unlock_cnt != 3'h0); // RQ1
      bod_unlock_cnt_ff <= nxt_bod_unlock_cnt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bod_st_ff  <= IOPM_BOD_IDLE;
      bod_cnt_ff <= 3'h0;
    end else begin
      bod_st_ff  <= nxt_bod_st; // RQ2
      bod_cnt_ff <= nxt_bod_cnt;
    end
  end

  // masking covers the unlock write cycle, the open window, and one more instruction
  wire vec_mask  = vec_arm || vec_open || irq_hold_ff; // RQ7
  wire lock_mask = (vec_sel_ff && app_section_lock_i && !pc_in_boot_i) ||
                   (!vec_sel_ff && boot_section_lock_i && pc_in_boot_i); // RQ10

  assign irq_allowed_o           = global_irq_en_i && !vec_mask && !lock_mask; // RQ8
  assign vector_table_select_o   = vec_sel_ff; // RQ5
  assign brownout_sleep_off_o    = bod_st_ff == IOPM_BOD_ACTIVE;
  assign brownout_detector_off_o = sleep_exec_i && brownout_sleep_off_o; // RQ3
  assign rdata_o     = rdata_ff;
  assign pb_pin_o    = pb_out_ff;
  assign pb_pin_oe_o = pb_dir_ff;
  assign pc_pin_o    = pc_out_ff;
  assign pc_pin_oe_o = pc_dir_ff;
  // pull-up only for inputs with output bit set, and never while killed
  assign pb_pullup_o = ~pb_dir_ff & pb_out_ff & {PB_WIDTH{~pullup_kill_ff}}; // RQ4
  assign pc_pullup_o = ~pc_dir_ff & pc_out_ff & {PC_WIDTH{~pullup_kill_ff}}; // RQ4

endmodule

// ===== inc/iopm_consts.svh
// register offsets, field positions, reset values and timing counts for the i/o port block
`ifndef IOPM_CONSTS_SVH
`define IOPM_CONSTS_SVH
`define IOPM_IO_OFFSET       8'h20
`define IOPM_IO_SPACE_MAX    8'h3f
`define IOPM_OFF_PB_IN       8'h23
`define IOPM_OFF_PB_DIR      8'h24
`define IOPM_OFF_PB_OUT      8'h25
`define IOPM_OFF_PC_IN       8'h26
`define IOPM_OFF_PC_DIR      8'h27
`define IOPM_OFF_PC_OUT      8'h28
`define IOPM_OFF_MCTL        8'h55
`define IOPM_BIT_BOD_OFF     6
`define IOPM_BIT_BOD_UNLOCK  5
`define IOPM_BIT_PULLUP_KILL 4
`define IOPM_BIT_VEC_SEL     1
`define IOPM_BIT_VEC_UNLOCK  0
`define IOPM_RST_BYTE        8'h00
`define IOPM_UNLOCK_CYC      3'h4
`define IOPM_BOD_DELAY_CYC   3'h3
`define IOPM_BOD_HOLD_CYC    3'h3
`endif

// ===== inc/iopm_pkg.sv
// types shared by the i/o port and micro control block
package iopm_pkg;
  typedef enum logic [2:0] {
    IOPM_BOD_IDLE  = 3'b001,
    IOPM_BOD_DELAY = 3'b010,
    IOPM_BOD_ACTIVE = 3'b100
  } iopm_bod_st_t;
endpackage

// ===== sim/iopm_io_port_props.sv
// concurrent checks on the io port block ports
`timescale 1ns/1ps
module iopm_io_port_props #(
  parameter int unsigned PB_WIDTH = 8
) (
  input wire logic                core_clk_i,
  input wire logic                rst_i,
  input wire logic [7:0]          addr_i,
  input wire logic                io_space_i,
  input wire logic                wr_en_i,
  input wire logic                rd_en_i,
  input wire logic [7:0]          wdata_i,
  input wire logic [7:0]          rdata_o,
  input wire logic                sleep_exec_i,
  input wire logic                pc_in_boot_i,
  input wire logic                app_section_lock_i,
  input wire logic                global_irq_en_i,
  input wire logic [PB_WIDTH-1:0] pb_pin_o,
  input wire logic [PB_WIDTH-1:0] pb_pin_oe_o,
  input wire logic [PB_WIDTH-1:0] pb_pullup_o,
  input wire logic                vector_table_select_o,
  input wire logic                irq_allowed_o,
  input wire logic                brownout_sleep_off_o,
  input wire logic                brownout_detector_off_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire ctl_hit = io_space_i ? (addr_i == 8'h35) : (addr_i == 8'h55);
  wire unl_wr  = wr_en_i && ctl_hit && wdata_i[0];
  rd_idle_a: assert property (!rd_en_i |=> rdata_o == 8'h00)
    else $error("read data not zero without a read");
  unl_mask_a: assert property (unl_wr |-> !irq_allowed_o)
    else $error("interrupts allowed during unlock write");
  gie_pass_a: assert property (irq_allowed_o |-> global_irq_en_i)
    else $error("interrupts allowed with global flag clear");
  bod_len_a: assert property ($rose(brownout_sleep_off_o) |->
    brownout_sleep_off_o [*3] ##1 !brownout_sleep_off_o) else $error("sleep-off length wrong");
  bod_cause_a: assert property ($rose(brownout_sleep_off_o) |->
    $past(wr_en_i, 3) || $past(wr_en_i, 4)) else $error("sleep-off without timed write");
  det_off_a: assert property (brownout_detector_off_o ==
    (sleep_exec_i && brownout_sleep_off_o)) else $error("detector off mismatch");
  pull_gate_a: assert property ((pb_pullup_o & (pb_pin_oe_o | ~pb_pin_o)) == '0)
    else $error("pull-up on for a driven or low pin");
  vec_cause_a: assert property ($changed(vector_table_select_o) |->
    $past(wr_en_i) && !$past(wdata_i[0])) else $error("vector select moved without commit");
  lock_block_a: assert property (vector_table_select_o && app_section_lock_i &&
    !pc_in_boot_i |-> !irq_allowed_o) else $error("interrupt allowed in locked section");
  cover property ($rose(brownout_sleep_off_o));
  cover property ($rose(vector_table_select_o));
  cover property (unl_wr);
endmodule

// ===== sim/iopm_core_model.sv
// processor core model issuing register reads and writes
`timescale 1ns/1ps
module iopm_core_model (
  input  wire logic       core_clk_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic            io_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial {wr_o, rd_o, io_o, addr_o, wdata_o} = '0;
  // changed on the falling edge, held across the sampling edge
  task automatic acc(input logic w, r, io, input logic [7:0] a, d);
    @(negedge core_clk_i);
    {wr_o, rd_o, io_o, addr_o, wdata_o} = {w, r, io, a, d};
    @(posedge core_clk_i);
  endtask
  // released bus shows the inverse of the last value, never a stale copy
  task automatic idle();
    acc(1'b0, 1'b0, !io_o, ~addr_o, ~wdata_o);
  endtask
  // timed pair of control writes; gap idles make a slow core
  task automatic seq(input logic [7:0] a, b, input int gap);
    acc(1'b1, 1'b0, 1'b0, 8'h55, a);
    repeat (gap) idle();
    acc(1'b1, 1'b0, 1'b1, 8'h35, b);
    idle();
  endtask
endmodule

// ===== sim/tb.sv
// self-checking bench for the io port block
`timescale 1ns/1ps
module tb;
  localparam int unsigned PB_WIDTH = 8;
  logic       core_clk_i = 0, rst_i = 1, sleep_exec_i = 0, pc_in_boot_i = 0, rd_q = 0;
  logic       app_section_lock_i = 0, global_irq_en_i = 1, wr_en_i, rd_en_i, io_space_i;
  logic       boot_section_lock_i = 0;
  logic [7:0] addr_i, wdata_i, rdata_o, pb_pin_i = 0, pb_pin_o, pb_pin_oe_o, pb_pullup_o, d, e, t;
  logic [6:0] pc_pin_i = 0, pc_pin_o, pc_pin_oe_o, pc_pullup_o;
  logic       vector_table_select_o, irq_allowed_o, brownout_sleep_off_o, brownout_detector_off_o;
  logic [7:0] ra[5] = '{8'h24, 8'h25, 8'h27, 8'h28, 8'h55};
  logic [7:0] exp_q[$];
  int         errors = 0, checks_done = 0, cyc = 0, n, m;
  iopm_core_model core (.core_clk_i(core_clk_i), .wr_o(wr_en_i), .rd_o(rd_en_i),
    .io_o(io_space_i), .addr_o(addr_i), .wdata_o(wdata_i));
  iopm_io_port #(.PB_WIDTH(8), .PC_WIDTH(7)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .io_space_i(io_space_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .sleep_exec_i(sleep_exec_i),
    .pc_in_boot_i(pc_in_boot_i), .app_section_lock_i(app_section_lock_i),
    .boot_section_lock_i(boot_section_lock_i), .global_irq_en_i(global_irq_en_i),
    .pb_pin_i(pb_pin_i), .pc_pin_i(pc_pin_i), .pb_pin_o(pb_pin_o), .pb_pin_oe_o(pb_pin_oe_o),
    .pb_pullup_o(pb_pullup_o), .pc_pin_o(pc_pin_o), .pc_pin_oe_o(pc_pin_oe_o),
    .pc_pullup_o(pc_pullup_o), .vector_table_select_o(vector_table_select_o),
    .irq_allowed_o(irq_allowed_o), .brownout_sleep_off_o(brownout_sleep_off_o),
    .brownout_detector_off_o(brownout_detector_off_o));
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic cmp(input string nm, input logic [7:0] ex, got);
    checks_done++;
    if (got !== ex) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rdc(input logic io, input logic [7:0] a, ex);
    exp_q.push_back(ex);
    core.acc(1'b0, 1'b1, io, a, 8'h00);
  endtask
  task automatic bod_cnt(input int gap, input logic [7:0] ex, ex_det);
    core.seq(8'h70, 8'h50, gap);
    n = 0;
    m = 0;
    repeat (10) begin
      @(negedge core_clk_i);
      n += (brownout_sleep_off_o === 1'b1);
      m += (brownout_detector_off_o === 1'b1);
    end
    cmp("sleep-off cycles", ex, n[7:0]);
    cmp("detector-off cycles", ex_det, m[7:0]);
  endtask
  always @(posedge core_clk_i) begin
    rd_q <= rd_en_i;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end
  // read data stands for the cycle after the read edge; look at it mid-cycle
  always @(negedge core_clk_i) begin
    if (rd_q) cmp("rdata", exp_q.pop_front(), rdata_o);
  end
  initial begin
    void'($urandom(32'h4f8e6412));
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i) rst_i = 0;
    foreach (ra[i]) rdc(1'b0, ra[i], 8'h00);
    rdc(1'b1, 8'h3f, 8'h00);
    rdc(1'b0, 8'h60, 8'h00);
    $display("reset values done");
    d = $urandom;
    e = $urandom;
    core.acc(1'b1, 1'b0, 1'b1, 8'h05, d);
    core.acc(1'b1, 1'b0, 1'b0, 8'h24, e);
    core.acc(1'b1, 1'b0, 1'b1, 8'h08, 8'hff);
    core.acc(1'b1, 1'b0, 1'b0, 8'h27, e);
    rdc(1'b0, 8'h25, d);
    rdc(1'b1, 8'h04, e);
    rdc(1'b0, 8'h28, 8'h7f);
    rdc(1'b1, 8'h07, e & 8'h7f);
    core.idle();
    cmp("pb out", d, pb_pin_o);
    cmp("pc oe", e & 8'h7f, {1'b0, pc_pin_oe_o});
    cmp("pc out", 8'h7f, {1'b0, pc_pin_o});
    cmp("pb oe", e, pb_pin_oe_o);
    $display("decode done");
    t = $urandom;
    @(negedge core_clk_i);
    pb_pin_i = 8'($urandom);
    pc_pin_i = 7'($urandom);
    core.acc(1'b1, 1'b0, 1'b1, 8'h03, t);
    core.idle();
    cmp("toggle", d ^ t, pb_pin_o);
    rdc(1'b0, 8'h23, pb_pin_i);
    rdc(1'b1, 8'h06, {1'b0, pc_pin_i});
    $display("toggle done");
    core.acc(1'b1, 1'b0, 1'b0, 8'h24, 8'h00);
    core.acc(1'b1, 1'b0, 1'b0, 8'h25, 8'hff);
    core.idle();
    cmp("pull-up", 8'hff, pb_pullup_o);
    cmp("pc pull-up", ~e & 8'h7f, {1'b0, pc_pullup_o});
    core.acc(1'b1, 1'b0, 1'b1, 8'h35, 8'h10);
    core.idle();
    cmp("pull-up kill", 8'h00, pb_pullup_o);
    cmp("pc pull-up kill", 8'h00, {1'b0, pc_pullup_o});
    $display("pull-up done");
    core.seq(8'h11, 8'h12, 0);
    cmp("vector select", 8'h01, {7'h00, vector_table_select_o});
    @(negedge core_clk_i) app_section_lock_i = 1;
    @(posedge core_clk_i) cmp("locked irq", 8'h00, {7'h00, irq_allowed_o});
    @(negedge core_clk_i) pc_in_boot_i = 1;
    @(posedge core_clk_i) cmp("boot irq", 8'h01, {7'h00, irq_allowed_o});
    core.acc(1'b1, 1'b0, 1'b0, 8'h55, 8'h11);
    repeat (6) core.idle();
    core.acc(1'b1, 1'b0, 1'b0, 8'h55, 8'h10);
    rdc(1'b0, 8'h55, 8'h12);
    core.seq(8'h11, 8'h10, 3);
    cmp("vector back", 8'h00, {7'h00, vector_table_select_o});
    @(negedge core_clk_i) boot_section_lock_i = 1;
    @(posedge core_clk_i) cmp("boot locked irq", 8'h00, {7'h00, irq_allowed_o});
    @(negedge core_clk_i) pc_in_boot_i = 0;
    @(posedge core_clk_i) cmp("app irq", 8'h01, {7'h00, irq_allowed_o});
    @(negedge core_clk_i) global_irq_en_i = 0;
    @(posedge core_clk_i) cmp("global off irq", 8'h00, {7'h00, irq_allowed_o});
    @(negedge core_clk_i) global_irq_en_i = 1;
    $display("vector done");
    @(negedge core_clk_i) sleep_exec_i = 1;
    bod_cnt(0, 8'h03, 8'h03);
    bod_cnt(5, 8'h00, 8'h00);
    @(negedge core_clk_i) sleep_exec_i = 0;
    bod_cnt(1, 8'h03, 8'h00);
    $display("brown-out done");
    stop_test();
  end
endmodule
bind iopm_io_port iopm_io_port_props #(.PB_WIDTH(PB_WIDTH)) chk (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .addr_i(addr_i), .io_space_i(io_space_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .sleep_exec_i(sleep_exec_i),
  .pc_in_boot_i(pc_in_boot_i), .app_section_lock_i(app_section_lock_i),
  .global_irq_en_i(global_irq_en_i), .pb_pin_o(pb_pin_o), .pb_pin_oe_o(pb_pin_oe_o),
  .pb_pullup_o(pb_pullup_o), .vector_table_select_o(vector_table_select_o),
  .irq_allowed_o(irq_allowed_o), .brownout_sleep_off_o(brownout_sleep_off_o),
  .brownout_detector_off_o(brownout_detector_off_o));
